// ---- hnc_host.sv ----
// flash command host: axi4-lite registers in, flash command cycles out
//
// How it works
// R1: after error flag, only F0 resets, reads and toggle polls accepted
// R2: after abort flag, only AA/55/F0 reset
// R3: poll reads use the software-given address
// R4: toggle op tracks progress, blank check included
// R5: lock register lives in flash only
// R6: password lock bit is device side
// R7: nonvolatile lock bit is device side
// R8: extended block bit is device side
// R9: lock bit conflict abort is device side
// R10: flag capture can be turned off
// R11: unlock pair AA/55 then command writes
// R12: AA, 55, 90 enters auto select
// R13: AA,55,20 enters bypass; 90,00 leaves
// R14: bypass program and erase skip unlocks
// R15: buffer: 25, count, pairs, then 29
// R16: confirm goes to latched block address
// R17: write cycle limit checked by device
// R18: buffer loads keep upper address bits
// R19: B0 suspends, 30 resumes, single write
// R20: chip erase six writes ending 10
// R21: block erase 30 writes, extendable
// R22: blank check EB,76,00,00 then 29
// R23: address before we falls, we rises first
// R24: erase timer flag read by software
// R25: toggle bit compared across two reads
// R26: bad sequences handled by device
// R27: host refuses commands while flags pending
`timescale 1ns/1ps
`default_nettype none
module hnc_host (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // flash pins
    output hnc_pkg::hnc_flash_type flash_o,
    input wire logic [15:0] dq_in
);
    import hnc_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_READ, S_GAP} hnc_state_type;

    // ****************
    // register file
    // ****************
    logic aw_got_r, w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [1:0] ctrl_r;
    logic [23:0] addr_r, blk_r;
    logic [15:0] data_r;
    logic [15:0] rdata_r, first_r;
    logic busy_r, refused_r, err_r, abort_r, toggled_r, bypass_r, autosel_r;
    hnc_op_type op_r;
    logic [3:0] idx_r, cnt_r;
    hnc_state_type st_r;
    logic wr_fire, cmd_wr, cmd_ok, step_done;
    hnc_op_type cmd_op;
    hnc_step_type step;
    logic [3:0] last_idx;

    assign s_awready = !aw_got_r && !s_bvalid;
    assign s_wready = !w_got_r && !s_bvalid;
    assign wr_fire = aw_got_r && w_got_r && !s_bvalid;
    assign cmd_wr = wr_fire && awaddr_r == REG_CMD && wdata_r[3:0] <= 4'hF;
    assign cmd_op = hnc_op_type'(wdata_r[3:0]);

    // pending error gates all but resets, reads and toggle polls; pending abort allows only the AA/55/F0 reset
    always_comb begin
        cmd_ok = !busy_r;
        if (abort_r && cmd_op != OP_RESET3) begin
            cmd_ok = 1'b0; // see R2
        end else if (err_r && !(cmd_op inside {OP_RESET1, OP_RESET3, OP_READ, OP_TOGGLE})) begin
            cmd_ok = 1'b0; // see R1 R27
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_wdata;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (awaddr_r inside {REG_CTRL, REG_ADDR, REG_DATA, REG_CMD})
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // byte strobes are ignored: every register is written as a whole word
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r <= 2'h0;
            addr_r <= 24'h00_0000;
            data_r <= 16'h0000;
        end else if (wr_fire) begin
            if (awaddr_r == REG_CTRL) begin
                ctrl_r <= wdata_r[1:0];
            end
            if (awaddr_r == REG_ADDR) begin
                addr_r <= wdata_r[23:0];
            end
            if (awaddr_r == REG_DATA) begin
                data_r <= wdata_r[15:0];
            end
        end
    end

    assign s_arready = !s_rvalid;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            case (s_araddr)
                REG_CTRL: s_rdata <= {30'h0, ctrl_r};
                REG_ADDR: s_rdata <= {8'h00, addr_r};
                REG_DATA: s_rdata <= {16'h0000, data_r};
                REG_STATUS: s_rdata <= {25'h0, autosel_r, bypass_r, toggled_r, abort_r,
                    err_r, refused_r, busy_r};
                REG_RDATA: s_rdata <= {16'h0000, rdata_r};
                default: begin
                    s_rdata <= 32'h0000_0000;
                    s_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // ****************
    // command sequence table
    // ****************
    logic [23:0] ua1, ua2, low_mask, buf_addr;
    logic [3:0] k;
    assign ua1 = ctrl_r[CTRL_WORD] ? UA_WORD1 : UA_BYTE1; // see R11
    assign ua2 = ctrl_r[CTRL_WORD] ? UA_WORD2 : UA_BYTE2;
    assign low_mask = ctrl_r[CTRL_WORD] ? LOW_WORD : LOW_BYTE;
    assign buf_addr = (blk_r & ~low_mask) | (addr_r & low_mask); // see R18

    always_comb begin
        // bypass skips the unlock pair; erase maps its two writes onto k 2 and 5
        k = idx_r;
        if (bypass_r && op_r inside {OP_PROGRAM, OP_BUF_START}) begin
            k = idx_r + 4'd2; // see R14
        end else if (bypass_r && op_r inside {OP_CHIP_ERASE, OP_BLOCK_ERASE}) begin
            k = (idx_r == 4'd0) ? 4'd2 : 4'd5; // see R14
        end
        step = '{addr: ua1, data: D_F0, rd: 1'b0};
        last_idx = 4'd0;
        case (op_r)
            OP_READ, OP_TOGGLE: begin
                step = '{addr: addr_r, data: D_00, rd: 1'b1}; // see R3
                last_idx = (op_r == OP_TOGGLE) ? 4'd1 : 4'd0; // see R4 R25
            end
            OP_RESET1: step.data = D_F0; // see R1
            OP_BYP_EXIT: begin
                step.data = (idx_r == 4'd0) ? D_90 : D_00; // see R13
                last_idx = 4'd1;
            end
            OP_BUF_LOAD: step = '{addr: buf_addr, data: data_r, rd: 1'b0}; // see R15
            OP_BUF_CONFIRM: step = '{addr: blk_r, data: D_29, rd: 1'b0}; // see R16
            OP_SUSPEND: step.data = D_B0; // see R19
            OP_RESUME: step.data = D_30; // see R19
            OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
                last_idx = bypass_r ? 4'd1 : 4'd5;
                case (k)
                    4'd0, 4'd3: step.data = D_AA; // see R20
                    4'd1, 4'd4: step = '{addr: ua2, data: D_55, rd: 1'b0};
                    4'd2: step.data = D_80;
                    default: step = '{addr: (op_r == OP_CHIP_ERASE) ? ua1 : addr_r, rd: 1'b0,
                        data: (op_r == OP_CHIP_ERASE) ? D_10 : D_30}; // see R20 R21
                endcase
            end
            default: begin
                // unlock pair then op-specific writes
                last_idx = (op_r == OP_BLANK_SETUP) ? 4'd5 : (op_r inside {OP_RESET3,
                    OP_AUTOSEL, OP_BYP_ENTER}) ? 4'd2 : (bypass_r ? 4'd1 : 4'd3);
                case (k)
                    4'd0: step.data = D_AA; // see R11
                    4'd1: step = '{addr: ua2, data: D_55, rd: 1'b0};
                    4'd2: begin
                        case (op_r)
                            OP_RESET3: step.data = D_F0; // see R2
                            OP_AUTOSEL: step.data = D_90; // see R12
                            OP_BYP_ENTER: step.data = D_20; // see R13
                            OP_PROGRAM: step.data = D_A0; // see R11
                            OP_BUF_START: step = '{addr: addr_r, data: D_25, rd: 1'b0};
                            default: step = '{addr: addr_r, data: D_EB, rd: 1'b0}; // see R22
                        endcase
                    end
                    4'd3: begin
                        case (op_r)
                            OP_PROGRAM: step = '{addr: addr_r, data: data_r, rd: 1'b0};
                            OP_BUF_START: step = '{addr: addr_r, data: data_r, rd: 1'b0};
                            default: step = '{addr: addr_r, data: D_76, rd: 1'b0};
                        endcase
                    end
                    default: step = '{addr: addr_r, data: D_00, rd: 1'b0};
                endcase
            end
        endcase
    end

    // ****************
    // bus cycle engine
    // ****************
    assign step_done = st_r == S_GAP && cnt_r == 4'd0;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= S_IDLE;
            cnt_r <= 4'd0;
            idx_r <= 4'd0;
            busy_r <= 1'b0;
            op_r <= OP_READ;
        end else begin
            cnt_r <= (cnt_r == 4'd0) ? 4'd0 : cnt_r - 4'd1;
            case (st_r)
                S_IDLE: begin
                    if (cmd_wr && cmd_ok) begin
                        op_r <= cmd_op;
                        idx_r <= 4'd0;
                        busy_r <= 1'b1;
                        st_r <= S_SETUP;
                        cnt_r <= SETUP_CYC - 4'd1;
                    end
                end
                S_SETUP: begin
                    if (cnt_r == 4'd0) begin
                        st_r <= step.rd ? S_READ : S_PULSE;
                        cnt_r <= step.rd ? ACCESS_CYC - 4'd1 : PULSE_CYC - 4'd1;
                    end
                end
                S_PULSE: begin
                    if (cnt_r == 4'd0) begin
                        st_r <= S_HOLD;
                        cnt_r <= HOLD_CYC - 4'd1;
                    end
                end
                S_HOLD, S_READ: begin
                    if (cnt_r == 4'd0) begin
                        st_r <= S_GAP;
                        cnt_r <= GAP_CYC - 4'd1;
                    end
                end
                S_GAP: begin
                    if (cnt_r == 4'd0) begin
                        if (idx_r == last_idx) begin
                            st_r <= S_IDLE;
                            busy_r <= 1'b0;
                        end else begin
                            idx_r <= idx_r + 4'd1;
                            st_r <= S_SETUP;
                            cnt_r <= SETUP_CYC - 4'd1;
                        end
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // address and ce lead we; we rises while ce is still low; oe stays high on writes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flash_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, byte_n: 1'b0,
                addr: 24'h00_0000, dq_out: 16'h0000, dq_oe_n: 1'b1};
        end else begin
            flash_o.rst_n <= 1'b1;
            flash_o.byte_n <= ctrl_r[CTRL_WORD];
            flash_o.ce_n <= !(st_r inside {S_SETUP, S_PULSE, S_HOLD, S_READ}); // see R23
            flash_o.we_n <= !(st_r == S_PULSE); // see R23
            flash_o.oe_n <= !(st_r == S_READ);
            flash_o.dq_oe_n <= !(st_r inside {S_SETUP, S_PULSE, S_HOLD} && !step.rd);
            if (st_r == S_SETUP) begin
                flash_o.addr <= step.addr;
                flash_o.dq_out <= step.data;
            end
        end
    end

    // ****************
    // status tracking
    // ****************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_r <= 16'h0000;
            first_r <= 16'h0000;
            toggled_r <= 1'b0;
            blk_r <= 24'h00_0000;
        end else begin
            if (st_r == S_READ && cnt_r == 4'd0) begin
                rdata_r <= dq_in;
                if (idx_r == 4'd0) begin
                    first_r <= dq_in;
                end else begin
                    toggled_r <= first_r[BIT_TOGGLE] ^ dq_in[BIT_TOGGLE]; // see R25
                end
            end
            if (step_done && op_r == OP_BUF_START && idx_r == last_idx) begin
                blk_r <= addr_r; // see R16
            end
        end
    end

    // flags come only from toggle polling, unless muted for the lock flow
    logic poll_sample;
    assign poll_sample = st_r == S_READ && cnt_r == 4'd0 && op_r == OP_TOGGLE
        && !ctrl_r[CTRL_NOFLAG]; // see R10
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            err_r <= 1'b0;
            abort_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            if (step_done && idx_r == last_idx && op_r == OP_RESET3) begin
                err_r <= 1'b0;
                abort_r <= 1'b0;
            end
            if (step_done && idx_r == last_idx && op_r == OP_RESET1) begin
                err_r <= 1'b0;
            end
            if (poll_sample && dq_in[BIT_ERROR]) begin
                err_r <= 1'b1; // see R1
            end
            if (poll_sample && dq_in[BIT_ABORT]) begin
                abort_r <= 1'b1; // see R2
            end
            if (cmd_wr) begin
                refused_r <= !(cmd_ok && st_r == S_IDLE); // see R27
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bypass_r <= 1'b0;
            autosel_r <= 1'b0;
        end else if (step_done && idx_r == last_idx) begin
            if (op_r == OP_BYP_ENTER) begin
                bypass_r <= 1'b1; // see R13
            end
            if (op_r inside {OP_BYP_EXIT, OP_RESET1, OP_RESET3}) begin
                bypass_r <= 1'b0;
            end
            autosel_r <= op_r == OP_AUTOSEL ? 1'b1 : (op_r inside {OP_RESET1, OP_RESET3})
                ? 1'b0 : autosel_r; // see R12
        end
    end

    // ****************
    // assertions
    // ****************
    property p_we_inside_ce;
        @(posedge clock) disable iff (sys_rst) !flash_o.we_n |-> !flash_o.ce_n && flash_o.oe_n;
    endproperty
    a_we_inside_ce: assert property (p_we_inside_ce) else $error("we low outside ce"); // see R23
    property p_we_rise_first;
        @(posedge clock) disable iff (sys_rst) $rose(flash_o.we_n) |-> !flash_o.ce_n;
    endproperty
    a_we_rise_first: assert property (p_we_rise_first) else $error("ce rose with we"); // see R23
    property p_addr_before_we;
        @(posedge clock) disable iff (sys_rst)
            $fell(flash_o.we_n) |-> $stable(flash_o.addr) && !$past(flash_o.ce_n);
    endproperty
    a_addr_before_we: assert property (p_addr_before_we) else $error("addr late"); // see R23
    property p_err_refuse;
        @(posedge clock) disable iff (sys_rst)
            cmd_wr && err_r && !abort_r && cmd_op == OP_PROGRAM |=> refused_r && !$rose(busy_r);
    endproperty
    a_err_refuse: assert property (p_err_refuse) else $error("command taken with error"); // see R1
    property p_abort_refuse;
        @(posedge clock) disable iff (sys_rst)
            cmd_wr && abort_r && cmd_op == OP_RESET1 |=> refused_r;
    endproperty
    a_abort_refuse: assert property (p_abort_refuse) else $error("short reset on abort"); // see R2
    property p_unlock_first;
        @(posedge clock) disable iff (sys_rst)
            st_r == S_PULSE && idx_r == 4'd0 && !bypass_r && op_r == OP_PROGRAM
            |-> flash_o.dq_out == D_AA && flash_o.addr == ua1;
    endproperty
    a_unlock_first: assert property (p_unlock_first) else $error("unlock missing"); // see R11
    property p_confirm_block;
        @(posedge clock) disable iff (sys_rst)
            st_r == S_PULSE && op_r == OP_BUF_CONFIRM |-> flash_o.addr == blk_r;
    endproperty
    a_confirm_block: assert property (p_confirm_block) else $error("confirm block differs"); // see R16
    property p_load_upper;
        @(posedge clock) disable iff (sys_rst) st_r == S_PULSE && op_r == OP_BUF_LOAD
            |-> (flash_o.addr & ~low_mask) == (blk_r & ~low_mask);
    endproperty
    a_load_upper: assert property (p_load_upper) else $error("buffer upper address moved"); // see R18
    property p_byp_exit;
        @(posedge clock) disable iff (sys_rst)
            step_done && op_r == OP_BYP_EXIT && idx_r == 4'd1 |=> !bypass_r ##1 !bypass_r;
    endproperty
    a_byp_exit: assert property (p_byp_exit) else $error("bypass not left"); // see R13
endmodule // hnc_host
`default_nettype wire

// ---- hnc_pkg.sv ----
// package: constants, register map and carriers for the flash command host
package hnc_pkg;
    // ****************
    // timing
    // ****************
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_SETUP_NS = 16;
    localparam int T_PULSE_NS = 40;
    localparam int T_HOLD_NS = 8;
    localparam int T_GAP_NS = 24;
    localparam int T_ACCESS_NS = 80;
    localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] GAP_CYC = 4'((T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ****************
    // register map (byte offsets)
    // ****************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTRL_WORD = 0;
    localparam int CTRL_NOFLAG = 1;
    // ****************
    // flash command codes and fields
    // ****************
    localparam logic [15:0] D_AA = 16'h00AA;
    localparam logic [15:0] D_55 = 16'h0055;
    localparam logic [15:0] D_F0 = 16'h00F0;
    localparam logic [15:0] D_90 = 16'h0090;
    localparam logic [15:0] D_00 = 16'h0000;
    localparam logic [15:0] D_20 = 16'h0020;
    localparam logic [15:0] D_A0 = 16'h00A0;
    localparam logic [15:0] D_25 = 16'h0025;
    localparam logic [15:0] D_29 = 16'h0029;
    localparam logic [15:0] D_B0 = 16'h00B0;
    localparam logic [15:0] D_30 = 16'h0030;
    localparam logic [15:0] D_80 = 16'h0080;
    localparam logic [15:0] D_10 = 16'h0010;
    localparam logic [15:0] D_EB = 16'h00EB;
    localparam logic [15:0] D_76 = 16'h0076;
    localparam logic [23:0] UA_BYTE1 = 24'h00_0AAA;
    localparam logic [23:0] UA_BYTE2 = 24'h00_0555;
    localparam logic [23:0] UA_WORD1 = 24'h00_0555;
    localparam logic [23:0] UA_WORD2 = 24'h00_02AA;
    localparam logic [23:0] LOW_WORD = 24'h00_01FF;
    localparam logic [23:0] LOW_BYTE = 24'h00_007F;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_ERROR = 5;
    localparam int BIT_ABORT = 1;

    typedef enum logic [3:0] {
        OP_READ, OP_TOGGLE, OP_RESET1, OP_RESET3, OP_AUTOSEL, OP_BYP_ENTER, OP_BYP_EXIT,
        OP_PROGRAM, OP_BUF_START, OP_BUF_LOAD, OP_BUF_CONFIRM, OP_SUSPEND, OP_RESUME,
        OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_BLANK_SETUP
    } hnc_op_type;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
        logic rd;
    } hnc_step_type;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic byte_n;
        logic [23:0] addr;
        logic [15:0] dq_out;
        logic dq_oe_n;
    } hnc_flash_type;
endpackage

// ---- hnc_flash_model.sv ----
// flash device model: logs command writes and answers status reads
`timescale 1ns/1ps
`default_nettype none
module hnc_flash_model (
    // host pins
    input wire hnc_pkg::hnc_flash_type pins,
    // status set by the bench
    input wire logic busy,
    input wire logic [15:0] flags,
    // read data
    output logic [15:0] dq_in
);
    import hnc_pkg::*;
    logic [23:0] addr_lat;
    logic [15:0] last = 16'h0000;
    logic tog = 1'b0;
    logic [39:0] wlog [0:63];
    int n_wr = 0;
    // shipped lock value, never programmed here
    logic [15:0] lock_r = 16'hFFFF;
    task automatic log_write;
        wlog[n_wr % 64] = {addr_lat, pins.dq_out};
        n_wr++;
    endtask
    // address on the later falling edge, data on the earlier rising edge
    always @(negedge pins.we_n) if (!pins.ce_n) addr_lat = pins.addr;
    always @(negedge pins.ce_n) if (!pins.we_n) addr_lat = pins.addr;
    always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n) log_write();
    always @(posedge pins.ce_n) if (!pins.we_n && pins.oe_n) log_write();
    always @(negedge pins.oe_n) if (busy) tog = !tog;
    // released bus shows the inverse of its last value, never a stale copy
    always @(dq_in) if (!pins.ce_n && !pins.oe_n) last = dq_in;
    assign dq_in = (!pins.ce_n && !pins.oe_n) ? {flags[15:7], busy & tog, flags[5:0]} : ~last;
endmodule // hnc_flash_model
`default_nettype wire

// ---- test_hnc_host.sv ----
// testbench for the flash command host
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_hnc_host;
    import hnc_pkg::*;
    logic clock, sys_rst, fm_busy, word, byp, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [1:0] bresp, rresp, r;
    logic [15:0] fm_flags, dq_in, d, mask;
    logic [23:0] a, blk, lw;
    hnc_flash_type flash_o;
    int n_mismatch, comparisons, n0, n_ld;
    int ops[] = '{4, 2, 3, 11, 12, 13, 14, 15, 7, 8, 5, 7, 8, 13, 14, 6};
    hnc_host dut (.clock(clock), .sys_rst(sys_rst), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .flash_o(flash_o), .dq_in(dq_in));
    hnc_flash_model fm (.pins(flash_o), .busy(fm_busy), .flags(fm_flags), .dq_in(dq_in));
    // {count, steps}: step = {address kind, code}; kind 0 any, 1/2 unlock, 3 given
    function automatic logic [75:0] seq_of(input int op, input logic bp);
        if (bp && op == 7) return {4'd2, 72'h0A_03DD};
        if (bp && op == 8) return {4'd2, 72'h32_53DD};
        if (bp && op == 13) return {4'd2, 72'h08_0010};
        if (bp && op == 14) return {4'd2, 72'h08_0330};
        case (op)
            2: return {4'd1, 72'h0F0};
            3: return {4'd3, 72'h1_AA25_51F0};
            4: return {4'd3, 72'h1_AA25_5190};
            5: return {4'd3, 72'h1_AA25_5120};
            6: return {4'd2, 72'h09_0000};
            7: return {4'd4, 72'h1AA2_551A_03DD};
            8: return {4'd4, 72'h1AA2_5532_53DD};
            9: return {4'd1, 72'h3DD};
            10: return {4'd1, 72'h329};
            11: return {4'd1, 72'h0B0};
            12: return {4'd1, 72'h030};
            13: return {4'd6, 72'h1A_A255_1801_AA25_5110};
            14: return {4'd6, 72'h1A_A255_1801_AA25_5330};
            default: return {4'd6, 72'h1A_A255_3EB3_7630_0300};
        endcase
    endfunction
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic cmd(input int op);
        axi_wr(REG_CMD, 32'(op));
        do axi_rd(REG_STATUS, st); while (st[0] !== 1'b0);
    endtask
    task automatic run_seq(input int op, input logic [23:0] ea);
        logic [75:0] t;
        logic [11:0] s;
        logic [39:0] e;
        int len;
        t = seq_of(op, byp);
        len = int'(t[75:72]);
        axi_wr(REG_ADDR, {8'h00, a});
        axi_wr(REG_DATA, {16'h0000, d});
        n0 = fm.n_wr;
        cmd(op);
        `CHK("write count", len, fm.n_wr - n0)
        for (int i = 0; i < len; i++) begin
            s = t[12 * (len - 1 - i) +: 12];
            e = fm.wlog[(n0 + i) % 64];
            e[15:0] = (s[7:0] == 8'hDD) ? d : {8'h00, s[7:0]};
            if (s[9:8] == 2'd3) e[39:16] = ea;
            if (s[9:8] == 2'd1) e[39:16] = word ? UA_WORD1 : UA_BYTE1;
            if (s[9:8] == 2'd2) e[39:16] = word ? UA_WORD2 : UA_BYTE2;
            `CHK("write step", e, fm.wlog[(n0 + i) % 64])
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // the whole run needs about a twentieth of this span
    initial begin
        #400_000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {sys_rst, fm_busy, byp, word} = 4'b1000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        {awaddr, araddr, wdata, fm_flags} = 64'h0;
        {n_mismatch, comparisons} = 0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        void'($urandom(32'h2ce6));
        axi_wr(8'h40, 32'h0000_0001);
        `CHK("unmapped write", RESP_SLVERR, r)
        axi_rd(8'h40, st);
        `CHK("unmapped read", 32'h0000_0000, st)
        `CHK("unmapped read resp", RESP_SLVERR, r)
        for (int w = 0; w < 2; w++) begin
            word = w[0];
            mask = word ? 16'hFFFF : 16'h00FF;
            lw = word ? LOW_WORD : LOW_BYTE;
            axi_wr(REG_CTRL, {31'h0, word});
            foreach (ops[k]) begin
                a = 24'($urandom);
                d = (ops[k] == 8) ? 16'($urandom_range(3)) : 16'($urandom) & mask;
                run_seq(ops[k], a);
                if (ops[k] inside {5, 6}) byp = (ops[k] == 5);
                `CHK("mode bits", {ops[k] == 4, byp}, st[6:5])
                if (ops[k] == 8) begin
                    blk = a;
                    n_ld = int'(d);
                    for (int j = 0; j <= n_ld; j++) begin
                        a = 24'($urandom);
                        d = 16'($urandom) & mask;
                        run_seq(9, (blk & ~lw) | (a & lw));
                    end
                    run_seq(10, blk);
                end
            end
        end
        fm_busy <= 1'b1;
        fm_flags <= 16'h0020;
        cmd(1);
        `CHK("toggled", 1'b1, st[4])
        `CHK("error pending", 1'b1, st[2])
        n0 = fm.n_wr;
        cmd(7);
        `CHK("refused", 1'b1, st[1])
        `CHK("refused writes", n0, fm.n_wr)
        fm_flags <= 16'h0002;
        run_seq(2, a);
        `CHK("error cleared", 1'b0, st[2])
        cmd(1);
        `CHK("abort pending", 1'b1, st[3])
        cmd(2);
        `CHK("short reset refused", 1'b1, st[1])
        run_seq(3, a);
        `CHK("abort cleared", 1'b0, st[3])
        axi_wr(REG_CTRL, 32'h0000_0003);
        cmd(1);
        `CHK("muted abort", 1'b0, st[3])
        fm_busy <= 1'b0;
        cmd(0);
        axi_rd(REG_RDATA, st);
        `CHK("read data", 32'h0000_0002, st)
        end_of_test();
    end
endmodule // test_hnc_host
`default_nettype wire
